// >>> pkg/upload_params.svh
`ifndef UPLOAD_PARAMS_SVH
`define UPLOAD_PARAMS_SVH

// Register byte addresses on the bus
`define REG_UPD_ADDR    8'h00
`define REG_PKT_STATUS  8'h04
`define REG_MAX_LEN     8'h08
`define REG_ENGINE      8'h0c

// Reset and fixed values
`define MAX_LEN_RESET   13'h05ee
`define IMPLIED_LEN     13'h05f8
`define RUNT_LEN        16'h003c
`define LAST_PAIR       6'h3e

// Descriptor layout offsets
`define STATUS_OFS      32'h00000004
`define FRAG_OFS        32'h00000008
`define LEN_OFS         32'h00000004
`define ENTRY_STEP      32'h00000008

// Constants for counters and fills
`define ZERO6           6'h00
`define ONE6            6'h01
`define ZERO13          13'h0000
`define ONE13           13'h0001
`define ZERO16          16'h0000
`define ONE16           16'h0001
`define ZERO19          19'h00000
`define ZERO24          24'h000000
`define ZERO30          30'h00000000
`define ZERO32          32'h00000000
`define ONE32           32'h00000001

// Status word, length entry and htrans bit positions
`define B_LEN_MSB       12
`define B_ERROR         14
`define B_DONE          15
`define B_OVERRUN       16
`define B_RUNT          17
`define B_ALIGN         18
`define B_CRC           19
`define B_LONG          20
`define B_DRIBBLE       23
`define B_EXHAUST       24
`define B_IPBAD         25
`define B_TCPBAD        26
`define B_UDPBAD        27
`define B_INLINE        28
`define B_IPOK          29
`define B_TCPOK         30
`define B_UDPOK         31
`define B_FINAL         31
`define B_HTRANS_ACT    1

`endif

// >>> pkg/upload_pkg.sv
package upload_pkg;

    // Engine states
    typedef enum {
        S_IDLE,
        S_RDSTAT,
        S_STALL,
        S_RDADDR,
        S_RDLEN,
        S_DATA,
        S_WRITE,
        S_DRAIN,
        S_WSTAT
    } state_t;

    // One receive byte with its packet-end information
    typedef struct packed {
        logic [7:0] data;
        logic       last;
        logic       overrun;
        logic       crcBad;
        logic       dribble;
        logic       ipSeen;
        logic       ipBad;
        logic       tcpSeen;
        logic       tcpBad;
        logic       udpSeen;
        logic       udpBad;
        logic       fragmented;
    } rx_beat_t;

    // Memory master request
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        byteOnly;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_t;

endpackage

// >>> design/upload_flag_merge.sv
`timescale 1ns/10ps
`include "upload_params.svh"

module upload_flag_merge (
    // Packet end information
    input  wire upload_pkg::rx_beat_t beat,
    input  wire logic [15:0]          totalLen,
    input  wire logic [12:0]          maxLen,
    // Error and checksum bits of the status word
    output logic [31:0]               flags
);

    logic runt;
    logic tooLong;
    logic anyErr;

    // Length checks against the runt floor and programmed ceiling
    assign runt    = totalLen < `RUNT_LEN;
    assign tooLong = totalLen > {3'h0, maxLen};
    // Summary covers the five receive error bits only
    assign anyErr  = beat.overrun | runt | (beat.crcBad & beat.dribble)
                   | beat.crcBad | tooLong;

    always_comb
    begin
        flags = `ZERO32;
        flags[`B_RUNT]    = runt;
        flags[`B_ALIGN]   = beat.crcBad & beat.dribble;
        flags[`B_CRC]     = beat.crcBad;
        flags[`B_LONG]    = tooLong;
        flags[`B_OVERRUN] = beat.overrun;
        flags[`B_DRIBBLE] = beat.dribble;
        flags[`B_IPBAD]   = beat.ipSeen & beat.ipBad;
        flags[`B_TCPBAD]  = beat.tcpSeen & !beat.fragmented & beat.tcpBad;
        flags[`B_UDPBAD]  = beat.udpSeen & !beat.fragmented & beat.udpBad;
        flags[`B_IPOK]    = beat.ipSeen;
        flags[`B_TCPOK]   = beat.tcpSeen & !beat.fragmented;
        flags[`B_UDPOK]   = beat.udpSeen & !beat.fragmented;
        flags[`B_ERROR]   = anyErr;
    end

endmodule // upload_flag_merge

// >>> design/upload_engine.sv
// Register access over AHB-Lite and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "upload_params.svh"

// Contract
// - Overrun sets bit 16
// - Runt under 60 bytes sets bit 17
// - Bad check plus dribble sets bit 18
// - Check sequence failure sets bit 19
// - Over programmed length sets bit 20
// - Dribble bit 23 is informational only
// - Buffers exhausted sets bit 24, discard rest
// - Header checksum mismatches in bits 25-27
// - IP header present sets bit 29
// - TCP/UDP checked only when unfragmented
// - Inline mode uses one 1528-byte buffer
// - Inline and done bits tested together
// - Fragment entries at byte-aligned physical addresses
// - Fragment length from bits 12 to 0
// - Final-fragment bit 31 stops further fetches
// - Uploaded byte count in bits 12:0
// - Bit 14 set on receive error; an overrun on a byte before the last sets bit 16 but not bit 14
// - Bit 15 set when upload finished
module upload_engine (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // Register bus
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic [31:0]               hrdata,
    // Memory master
    output upload_pkg::mem_req_t      memReq,
    input  wire logic                 memAck,
    input  wire logic [31:0]          memRdata,
    // Receive byte stream
    input  wire logic                 rxValid,
    input  wire upload_pkg::rx_beat_t rxBeat,
    output logic                      rxReady
);

    upload_pkg::state_t   state;
    upload_pkg::state_t   next_state;
    upload_pkg::mem_req_t next_memReq;
    logic [31:0] updAddr;
    logic [31:0] next_updAddr;
    logic [31:0] entryAddr;
    logic [31:0] next_entryAddr;
    logic [31:0] fragAddr;
    logic [31:0] next_fragAddr;
    logic [12:0] fragRemain;
    logic [12:0] next_fragRemain;
    logic        fragLast;
    logic        next_fragLast;
    logic [5:0]  pairCount;
    logic [5:0]  next_pairCount;
    logic [31:0] status;
    logic [31:0] next_status;
    logic [15:0] byteTotal;
    logic [15:0] next_byteTotal;
    logic        endSeen;
    logic        next_endSeen;
    logic        next_rxReady;
    logic [31:0] next_hrdata;
    logic        wrPend;
    logic        next_wrPend;
    logic [7:0]  wrAddr;
    logic [7:0]  next_wrAddr;
    logic [12:0] maxLen;
    logic [12:0] next_maxLen;
    logic        consume;
    logic        updWrite;
    logic        toStatus;
    logic [15:0] totalNow;
    logic [31:0] flagWord;

    // Handshake and data-phase write strobes
    assign consume  = rxValid && rxReady;
    assign updWrite = wrPend && (wrAddr == `REG_UPD_ADDR);
    assign totalNow = byteTotal + `ONE16;

    // Packet-end flag word
    upload_flag_merge u_upload_flag_merge (
        .beat     (rxBeat),
        .totalLen (totalNow),
        .maxLen   (maxLen),
        .flags    (flagWord)
    );

    // Engine next-state logic
    always_comb
    begin
        next_state      = state;
        next_memReq     = memReq;
        next_updAddr    = updAddr;
        next_entryAddr  = entryAddr;
        next_fragAddr   = fragAddr;
        next_fragRemain = fragRemain;
        next_fragLast   = fragLast;
        next_pairCount  = pairCount;
        next_status     = status;
        next_byteTotal  = byteTotal;
        next_endSeen    = endSeen;
        toStatus        = 1'b0;
        case (state)
            upload_pkg::S_IDLE, upload_pkg::S_STALL:
            begin
                if (updWrite && (hwdata != `ZERO32))
                begin
                    next_updAddr         = hwdata;
                    next_status          = `ZERO32;
                    next_byteTotal       = `ZERO16;
                    next_pairCount       = `ZERO6;
                    next_endSeen         = 1'b0;
                    next_memReq.valid    = 1'b1;
                    next_memReq.write    = 1'b0;
                    next_memReq.byteOnly = 1'b0;
                    next_memReq.addr     = hwdata + `STATUS_OFS;
                    next_state           = upload_pkg::S_RDSTAT;
                end
            end
            upload_pkg::S_RDSTAT:
            begin
                if (memAck)
                begin
                    next_memReq.valid = 1'b0;
                    if (memRdata[`B_DONE])
                        next_state = upload_pkg::S_STALL;
                    else if (memRdata[`B_INLINE])
                    begin
                        next_fragAddr           = updAddr + `FRAG_OFS;
                        next_fragRemain         = `IMPLIED_LEN;
                        next_fragLast           = 1'b1;
                        next_status[`B_INLINE]  = 1'b1;
                        next_state              = upload_pkg::S_DATA;
                    end
                    else
                    begin
                        next_entryAddr    = updAddr + `FRAG_OFS;
                        next_memReq.valid = 1'b1;
                        next_memReq.addr  = updAddr + `FRAG_OFS;
                        next_state        = upload_pkg::S_RDADDR;
                    end
                end
            end
            upload_pkg::S_RDADDR:
            begin
                if (memAck)
                begin
                    next_fragAddr    = memRdata;
                    next_memReq.addr = entryAddr + `LEN_OFS;
                    next_state       = upload_pkg::S_RDLEN;
                end
            end
            upload_pkg::S_RDLEN:
            begin
                if (memAck)
                begin
                    next_memReq.valid = 1'b0;
                    next_fragRemain   = memRdata[`B_LEN_MSB:0];
                    next_fragLast     = memRdata[`B_FINAL]
                                      || (pairCount == `LAST_PAIR);
                    next_pairCount    = pairCount + `ONE6;
                    next_entryAddr    = entryAddr + `ENTRY_STEP;
                    next_state        = upload_pkg::S_DATA;
                end
            end
            upload_pkg::S_DATA:
            begin
                if (consume && (fragRemain != `ZERO13))
                begin
                    next_memReq.valid    = 1'b1;
                    next_memReq.write    = 1'b1;
                    next_memReq.byteOnly = 1'b1;
                    next_memReq.addr     = fragAddr;
                    next_memReq.wdata    = {`ZERO24, rxBeat.data};
                    next_state           = upload_pkg::S_WRITE;
                end
                else if (consume)
                begin
                    next_status[`B_EXHAUST] = 1'b1;
                    if (rxBeat.last)
                        toStatus = 1'b1;
                    else
                        next_state = upload_pkg::S_DRAIN;
                end
                else if ((fragRemain == `ZERO13) && !fragLast)
                begin
                    next_memReq.valid    = 1'b1;
                    next_memReq.write    = 1'b0;
                    next_memReq.byteOnly = 1'b0;
                    next_memReq.addr     = entryAddr;
                    next_state           = upload_pkg::S_RDADDR;
                end
            end
            upload_pkg::S_WRITE:
            begin
                if (memAck)
                begin
                    next_memReq.valid = 1'b0;
                    next_fragAddr     = fragAddr + `ONE32;
                    next_fragRemain   = fragRemain - `ONE13;
                    next_status[`B_LEN_MSB:0] = status[`B_LEN_MSB:0]
                                              + `ONE13;
                    if (endSeen)
                        toStatus = 1'b1;
                    else
                        next_state = upload_pkg::S_DATA;
                end
            end
            upload_pkg::S_DRAIN:
            begin
                if (consume && rxBeat.last)
                    toStatus = 1'b1;
            end
            upload_pkg::S_WSTAT:
            begin
                if (memAck)
                begin
                    next_memReq.valid = 1'b0;
                    next_updAddr      = `ZERO32;
                    next_state        = upload_pkg::S_IDLE;
                end
            end
            default:
            begin
                next_memReq.valid = 1'b0;
                next_state        = upload_pkg::S_IDLE;
            end
        endcase
        if (consume)
        begin
            next_byteTotal = totalNow;
            if (rxBeat.overrun)
                next_status[`B_OVERRUN] = 1'b1;
            if (rxBeat.last)
            begin
                next_endSeen = 1'b1;
                next_status  = next_status | flagWord;
            end
        end
        if (toStatus)
        begin
            next_status[`B_DONE] = 1'b1;
            next_memReq.valid    = 1'b1;
            next_memReq.write    = 1'b1;
            next_memReq.byteOnly = 1'b0;
            next_memReq.addr     = updAddr + `STATUS_OFS;
            next_memReq.wdata    = next_status;
            next_state           = upload_pkg::S_WSTAT;
        end
        next_rxReady = (next_state == upload_pkg::S_DRAIN)
                     || ((next_state == upload_pkg::S_DATA)
                         && ((next_fragRemain != `ZERO13) || next_fragLast));
    end

    // Engine registers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state      <= upload_pkg::S_IDLE;
            memReq     <= '0;
            updAddr    <= `ZERO32;
            entryAddr  <= `ZERO32;
            fragAddr   <= `ZERO32;
            fragRemain <= `ZERO13;
            fragLast   <= 1'b0;
            pairCount  <= `ZERO6;
            status     <= `ZERO32;
            byteTotal  <= `ZERO16;
            endSeen    <= 1'b0;
            rxReady    <= 1'b0;
        end
        else
        begin
            state      <= next_state;
            memReq     <= next_memReq;
            updAddr    <= next_updAddr;
            entryAddr  <= next_entryAddr;
            fragAddr   <= next_fragAddr;
            fragRemain <= next_fragRemain;
            fragLast   <= next_fragLast;
            pairCount  <= next_pairCount;
            status     <= next_status;
            byteTotal  <= next_byteTotal;
            endSeen    <= next_endSeen;
            rxReady    <= next_rxReady;
        end
    end

    // Bus slave next values, zero wait, read data from address phase
    always_comb
    begin
        next_wrPend = hsel && htrans[`B_HTRANS_ACT] && hready && hwrite;
        next_wrAddr = haddr[7:0];
        next_hrdata = hrdata;
        next_maxLen = maxLen;
        if (wrPend && (wrAddr == `REG_MAX_LEN))
            next_maxLen = hwdata[`B_LEN_MSB:0];
        if (hsel && htrans[`B_HTRANS_ACT] && hready && !hwrite)
        begin
            case (haddr[7:0])
                `REG_UPD_ADDR:   next_hrdata = updAddr;
                `REG_PKT_STATUS: next_hrdata = status;
                `REG_MAX_LEN:    next_hrdata = {`ZERO19, maxLen};
                `REG_ENGINE:     next_hrdata = {`ZERO30,
                                     state == upload_pkg::S_STALL,
                                     state != upload_pkg::S_IDLE};
                default:         next_hrdata = `ZERO32;
            endcase
        end
    end

    // Bus slave registers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wrPend    <= 1'b0;
            wrAddr    <= 8'h00;
            hrdata    <= `ZERO32;
            maxLen    <= `MAX_LEN_RESET;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            wrPend    <= next_wrPend;
            wrAddr    <= next_wrAddr;
            hrdata    <= next_hrdata;
            maxLen    <= next_maxLen;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_lastBeat;
        rxValid && rxReady && rxBeat.last;
    endsequence
    sequence s_statusAck;
        (state == upload_pkg::S_RDSTAT) && memAck;
    endsequence
    sequence s_lenAck;
        (state == upload_pkg::S_RDLEN) && memAck;
    endsequence
    sequence s_statusWrite;
        (state == upload_pkg::S_WSTAT) && memReq.valid;
    endsequence

    property p_overrun;
        (rxValid && rxReady && rxBeat.overrun) |=> status[`B_OVERRUN];
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun flag not set");
    property p_runt;
        s_lastBeat and (totalNow < `RUNT_LEN) |=> status[`B_RUNT];
    endproperty
    a_runt: assert property (p_runt)
        else $error("runt flag not set");
    property p_align;
        s_lastBeat |=> status[`B_ALIGN]
            == ($past(rxBeat.crcBad) && $past(rxBeat.dribble));
    endproperty
    a_align: assert property (p_align)
        else $error("alignment flag wrong");
    property p_crc;
        s_lastBeat |=> status[`B_CRC] == $past(rxBeat.crcBad);
    endproperty
    a_crc: assert property (p_crc)
        else $error("check failure flag wrong");
    property p_long;
        s_lastBeat and (totalNow > {3'h0, maxLen}) |=> status[`B_LONG];
    endproperty
    a_long: assert property (p_long)
        else $error("oversize flag not set");
    property p_dribble;
        s_lastBeat |=> status[`B_DRIBBLE] == $past(rxBeat.dribble);
    endproperty
    a_dribble: assert property (p_dribble)
        else $error("dribble flag wrong");
    property p_exhaust;
        (state == upload_pkg::S_DATA) && consume && (fragRemain == `ZERO13)
        |=> status[`B_EXHAUST] && !(memReq.valid && memReq.byteOnly);
    endproperty
    a_exhaust: assert property (p_exhaust)
        else $error("exhausted byte not discarded");
    property p_ipBad;
        s_lastBeat |=> status[`B_IPBAD]
            == ($past(rxBeat.ipSeen) && $past(rxBeat.ipBad));
    endproperty
    a_ipBad: assert property (p_ipBad)
        else $error("ip mismatch flag wrong");
    property p_ipSeen;
        s_lastBeat |=> status[`B_IPOK] == $past(rxBeat.ipSeen);
    endproperty
    a_ipSeen: assert property (p_ipSeen)
        else $error("ip present flag wrong");
    property p_fragment;
        s_lastBeat and rxBeat.fragmented
        |=> !status[`B_TCPOK] && !status[`B_UDPOK];
    endproperty
    a_fragment: assert property (p_fragment)
        else $error("fragment marked as checked");
    property p_inline;
        s_statusAck and !memRdata[`B_DONE] && memRdata[`B_INLINE]
        |=> (state == upload_pkg::S_DATA) && fragLast
            && (fragAddr == updAddr + `FRAG_OFS)
            && (fragRemain == `IMPLIED_LEN);
    endproperty
    a_inline: assert property (p_inline)
        else $error("inline buffer not set up");
    property p_doneStall;
        s_statusAck and memRdata[`B_DONE]
        |=> (state == upload_pkg::S_STALL) && !memReq.valid;
    endproperty
    a_doneStall: assert property (p_doneStall)
        else $error("used descriptor not stalled");
    property p_entryStep;
        s_lenAck |=> entryAddr == $past(entryAddr) + `ENTRY_STEP;
    endproperty
    a_entryStep: assert property (p_entryStep)
        else $error("entry pointer step wrong");
    property p_length;
        s_lenAck |=> fragRemain == $past(memRdata[`B_LEN_MSB:0]);
    endproperty
    a_length: assert property (p_length)
        else $error("fragment length wrong");
    property p_final;
        (state == upload_pkg::S_DATA) && fragLast
        |=> state != upload_pkg::S_RDADDR;
    endproperty
    a_final: assert property (p_final)
        else $error("fetch past final fragment");
    property p_count;
        (state == upload_pkg::S_WRITE) && memAck
        |=> status[`B_LEN_MSB:0] == $past(status[`B_LEN_MSB:0]) + `ONE13;
    endproperty
    a_count: assert property (p_count)
        else $error("byte count not advanced");
    property p_errWord;
        s_statusWrite |-> memReq.wdata[`B_ERROR]
            == |memReq.wdata[`B_LONG:`B_OVERRUN];
    endproperty
    a_errWord: assert property (p_errWord)
        else $error("error bit wrong in written word");
    property p_doneWord;
        s_statusWrite |-> memReq.wdata[`B_DONE]
            && (memReq.addr == updAddr + `STATUS_OFS);
    endproperty
    a_doneWord: assert property (p_doneWord)
        else $error("completion word wrong");
    property p_summary;
        (state == upload_pkg::S_WSTAT)
        |-> status[`B_ERROR] == |status[`B_LONG:`B_OVERRUN];
    endproperty
    a_summary: assert property (p_summary)
        else $error("summary error flag wrong");

endmodule // upload_engine

// >>> bench/upload_mem_model.sv
`timescale 1ns/10ps
module upload_mem_model (
    // Request side
    input  wire logic                 clk,
    input  wire upload_pkg::mem_req_t memReq,
    input  wire logic [3:0]           lat,
    // Answer side
    output logic                      memAck,
    output logic [31:0]               memRdata
);
    logic [31:0] mem [logic [29:0]];
    logic [3:0]  cnt = 4'h0;
    initial memAck = 1'b0;
    initial memRdata = 32'h0;
    // Ack after lat cycles; data scrambles once the ack is gone
    always @(posedge clk)
    begin
        if (memReq.valid && !memAck && cnt == lat)
        begin
            cnt <= 4'h0;
            memAck <= 1'b1;
            memRdata <= mem[memReq.addr[31:2]];
            if (memReq.write && memReq.byteOnly)
                mem[memReq.addr[31:2]][{memReq.addr[1:0], 3'h0} +: 8]
                    = memReq.wdata[7:0];
            else if (memReq.write)
                mem[memReq.addr[31:2]] = memReq.wdata;
        end
        else
        begin
            memAck <= 1'b0;
            memRdata <= ~memRdata;
            cnt <= cnt + {3'h0, memReq.valid && !memAck};
        end
    end
endmodule // upload_mem_model

// >>> bench/upload_engine_tb_top.sv
`timescale 1ns/10ps
module upload_engine_tb_top;
    // Bench signals
    logic                 clk = 1'b0;
    logic                 rst_n = 1'b0;
    logic                 hsel = 1'b0;
    logic                 hwrite = 1'b0;
    logic                 rxValid = 1'b0;
    logic                 hready, hreadyout, hresp, memAck, rxReady;
    logic [1:0]           htrans = 2'h0;
    logic [2:0]           hsize = 3'h2;
    logic [3:0]           lat = 4'h0;
    logic [31:0]          haddr = 32'h0;
    logic [31:0]          hwdata = 32'h0;
    logic [31:0]          hrdata, memRdata, r;
    upload_pkg::rx_beat_t rxBeat = '0;
    upload_pkg::mem_req_t memReq;
    int                   failCount = 0;
    int                   cmpCount = 0;
    int                   cyc = 0;
`define CHK(n, e, s) begin cmpCount++; if ((s) !== (e)) begin \
failCount++; $display("Error %s exp %h got %h", n, e, s); end end
    // Clock, single-slave ready, instances
    always #20 clk = ~clk;
    assign hready = hreadyout;
    upload_engine u_upload_engine (
        .clk       (clk),
        .rst_n     (rst_n),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .memReq    (memReq),
        .memAck    (memAck),
        .memRdata  (memRdata),
        .rxValid   (rxValid),
        .rxBeat    (rxBeat),
        .rxReady   (rxReady)
    );
    upload_mem_model u_upload_mem_model (
        .clk      (clk),
        .memReq   (memReq),
        .lat      (lat),
        .memAck   (memAck),
        .memRdata (memRdata)
    );
    // Verdict and end of run
    task automatic conclude();
        if (failCount == 0 && cmpCount > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            failCount++;
            conclude();
        end
    end
    // One AHB word transfer; read data lands in r
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
        `CHK("hresp", 1'b0, hresp)
    endtask
    // Stream n bytes a0, a1, ...; t holds the packet-end flags
    task automatic send(input int n, input upload_pkg::rx_beat_t t);
        for (int i = 0; i < n; i++)
        begin
            t.data = 8'ha0 + 8'(i);
            t.last = (i == n - 1);
            rxBeat <= t;
            rxValid <= 1'b1;
            do @(posedge clk); while (rxReady !== 1'b1);
        end
        rxValid <= 1'b0;
    endtask
    // Host memory access and engine polling
    task automatic put(input logic [31:0] a, input logic [31:0] d);
        u_upload_mem_model.mem[a[31:2]] = d;
    endtask
    function automatic logic [31:0] peek(input logic [31:0] a);
        return u_upload_mem_model.mem[a[31:2]];
    endfunction
    task automatic waitEngine(input logic [31:0] v);
        do bus(1'b0, 8'h0c, 32'h0); while (r !== v);
    endtask
    // Main sequence
    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b0, 8'h08, 32'h0);
        `CHK("maxLen", 32'h5ee, r)
        bus(1'b0, 8'h10, 32'h0);
        `CHK("unmapped", 32'h0, r)
        put(32'h104, 32'h0);
        put(32'h108, 32'h203);
        put(32'h10c, 32'h2);
        put(32'h110, 32'h300);
        put(32'h114, 32'h80000001);
        put(32'h200, 32'h0);
        put(32'h204, 32'h0);
        put(32'h300, 32'h0);
        bus(1'b1, 8'h00, 32'h104 - 32'h4);
        send(5, {8'h0, 11'b00111111001});
        waitEngine(32'h0);
        `CHK("st", 32'h238ec003, peek(32'h104))
        `CHK("b0", 32'ha0000000, peek(32'h200))
        `CHK("b1", 32'h000000a1, peek(32'h204))
        `CHK("b2", 32'h000000a2, peek(32'h300))
        bus(1'b0, 8'h04, 32'h0);
        `CHK("live", 32'h238ec003, r)
        bus(1'b0, 8'h00, 32'h0);
        `CHK("updClr", 32'h0, r)
        lat <= 4'h3;
        bus(1'b1, 8'h08, 32'h1);
        bus(1'b0, 8'h08, 32'h0);
        `CHK("maxLenWr", 32'h1, r)
        put(32'h404, 32'h10000000);
        put(32'h408, 32'h0);
        bus(1'b1, 8'h00, 32'h400);
        send(2, {8'h0, 11'b01000011110});
        waitEngine(32'h0);
        `CHK("st", 32'hdc13c002, peek(32'h404))
        `CHK("in", 32'h0000a1a0, peek(32'h408))
        put(32'h504, 32'h00008000);
        bus(1'b1, 8'h00, 32'h500);
        waitEngine(32'h3);
        `CHK("stall", 32'h8000, peek(32'h504))
        conclude();
    end
endmodule // upload_engine_tb_top
